// >>> cmp_control_page.sv
// Control mode page register bank with APB slave and setting decode
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module cmp_control_page
    import cmp_pkg::*;
#(
    parameter int SELFTEST_W = 32
)
(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [5:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [SELFTEST_W-1:0] SELFTEST_SECONDS,
    output logic             PI_CHECK_EN,
    output logic             SENSE_DESCRIPTOR,
    output logic [1:0]       REORDER_MODE,
    output logic [1:0]       QERR_MODE,
    output logic             APP_TAG_PRESERVE,
    output logic             APP_TAG_CHECK_EN,
    output logic             APP_TAG_FROM_PAGE,
    output logic             REJECT_WRITE,
    output logic             SBLP_PAGE_EN,
    output logic [2:0]       SPT_VALUE,
    output logic             UNIT_ATTENTION
);

    // The estimate input must carry the full 16-bit field;
    // a narrower port could never reach the saturation code
    if (SELFTEST_W < 16)
    begin : gen_width_check
        $error("SELFTEST_W must be at least 16");
    end

    // Stored settings
    logic [7:0]  prot_sense_reg;
    logic [7:0]  queue_control_reg;
    logic [7:0]  app_tag_reg;
    logic [15:0] busy_timeout_reg;
    logic [15:0] selftest_reg;
    logic [4:0]  cmd_in_reg;
    logic        ua_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;

    // Byte-lane merge of a write into a stored byte
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                              input logic [7:0] mask, input logic en);
        merge_byte = en ? ((old_v & ~mask) | (new_v & mask)) : old_v;
    endfunction

    // APB decode; access phase answered after one wait state
    wire        access     = PSEL && PENABLE && !pready_reg;
    wire [3:0]  word_idx   = PADDR[5:2];
    wire        wr_acc     = access && PWRITE;
    wire        hit_page   = (word_idx <= IDX_SELFTEST_TIME);
    wire        hit_own    = (word_idx == IDX_CMD_INPUT) || (word_idx == IDX_CMD_RESULT)
                             || (word_idx == IDX_EVENT_STATUS);
    wire        mapped     = hit_page || hit_own;
    wire        wr_prot    = wr_acc && word_idx == IDX_PROT_SENSE && PSTRB[0];
    wire        wr_queue   = wr_acc && word_idx == IDX_QUEUE_CONTROL && PSTRB[0];
    wire        wr_app     = wr_acc && word_idx == IDX_APP_TAG_CTRL && PSTRB[0];
    wire        wr_busy    = wr_acc && word_idx == IDX_BUSY_TIMEOUT;
    wire        wr_cmd     = wr_acc && word_idx == IDX_CMD_INPUT && PSTRB[0];
    wire        wr_status  = wr_acc && word_idx == IDX_EVENT_STATUS && PSTRB[0];

    // Reserved queue codes are refused; whole write dropped
    wire [3:0]  new_qam    = PWDATA[QAM_LSB+3:QAM_LSB];
    wire [1:0]  new_qerr   = PWDATA[QERR_LSB+1:QERR_LSB];
    wire        qam_ok     = new_qam == QAM_RESTRICTED || new_qam == QAM_UNRESTRICTED
                             || new_qam == QAM_DISABLED;
    wire        qerr_ok    = new_qerr != QERR_RESERVED;
    wire        queue_bad  = wr_queue && !(qam_ok && qerr_ok);
    wire        err_next   = access && (!mapped || queue_bad);

    // Next values of the settings; fixed fields masked off
    wire [7:0]  prot_sense_next = merge_byte(prot_sense_reg, PWDATA[7:0], PROT_SENSE_MASK,
                                             wr_prot);
    wire [7:0]  queue_next      = merge_byte(queue_control_reg, PWDATA[7:0], QUEUE_CTRL_MASK,
                                             wr_queue && !queue_bad);
    wire [7:0]  app_tag_next    = merge_byte(app_tag_reg, PWDATA[7:0], APP_TAG_MASK, wr_app);
    // Stored only; nothing acts on it
    wire [15:0] busy_next       = wr_busy ? {merge_byte(busy_timeout_reg[15:8], PWDATA[15:8],
                                  8'hFF, PSTRB[1]), merge_byte(busy_timeout_reg[7:0],
                                  PWDATA[7:0], 8'hFF, PSTRB[0])} : busy_timeout_reg;

    // Self-test time in seconds, clamped at the top code
    wire        st_over    = |(SELFTEST_SECONDS >> 16);
    wire [15:0] selftest_next = st_over ? SELFTEST_SAT : SELFTEST_SECONDS[15:0];

    // Any change of SBLP sets attention; set wins over clear
    wire        sblp_flip  = app_tag_next[SBLP_BIT] != app_tag_reg[SBLP_BIT];
    wire        ua_next    = sblp_flip ? 1'b1 : (wr_status && PWDATA[0]) ? 1'b0 : ua_reg;

    // Command descriptor: bit0 protect field zero, bit1 app check supported,
    // bit2 unprotected write, bit3 medium has PI
    wire        cmd_prot_zero = cmd_in_reg[0];
    wire        cmd_app_sup   = cmd_in_reg[1];
    wire        cmd_wr_nopi   = cmd_in_reg[2];
    wire        cmd_media_pi  = cmd_in_reg[3];

    // Settings decode
    wire        dpicz      = prot_sense_reg[DPICZ_BIT];
    wire        ato        = app_tag_reg[ATO_BIT];
    wire        atmpe      = app_tag_reg[ATMPE_BIT];
    wire        pi_chk     = !(dpicz && cmd_prot_zero);
    wire [3:0]  cur_qam    = queue_control_reg[QAM_LSB+3:QAM_LSB];
    wire [1:0]  cur_qerr   = queue_control_reg[QERR_LSB+1:QERR_LSB];
    // Restricted / unrestricted / disabled ordering
    wire [1:0]  order_next = (cur_qam == QAM_DISABLED)     ? 2'(QO_DISABLED) :
                             (cur_qam == QAM_UNRESTRICTED) ? 2'(QO_UNRESTRICTED) :
                                                             2'(QO_RESTRICTED);
    // Queue error handling code passed to the task manager
    wire [1:0]  qerr_next  = cur_qerr;
    wire        tag_keep   = ato;
    wire        tag_chk    = ato && pi_chk;
    wire        tag_page   = atmpe && ato && pi_chk && cmd_app_sup;
    wire        rej_next   = app_tag_reg[RWWP_BIT] && cmd_media_pi && cmd_wr_nopi;
    wire        sblp       = app_tag_reg[SBLP_BIT];
    wire [2:0]  spt_next   = sblp ? SPT_SBLP_VAL : 3'h0;

    // Read mux; narrow registers sit in the low bits
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (word_idx)
            IDX_PAGE_HEADER:   rd_mux = {24'h0, PAGE_HEADER_VAL};
            IDX_PAGE_LENGTH:   rd_mux = {24'h0, PAGE_LENGTH_VAL};
            IDX_PROT_SENSE:    rd_mux = {24'h0, prot_sense_reg};
            IDX_QUEUE_CONTROL: rd_mux = {24'h0, queue_control_reg};
            IDX_FIXED_FLAGS:   rd_mux = 32'h0000_0000;
            IDX_APP_TAG_CTRL:  rd_mux = {24'h0, app_tag_reg};
            IDX_BUSY_TIMEOUT:  rd_mux = {16'h0, busy_timeout_reg};
            IDX_SELFTEST_TIME: rd_mux = {16'h0, selftest_reg};
            IDX_CMD_INPUT:     rd_mux = {27'h0, cmd_in_reg};
            IDX_CMD_RESULT:    rd_mux = {24'h0, tag_page, rej_next, sblp, tag_chk,
                                         pi_chk, prot_sense_reg[DSENSE_BIT], 2'h0};
            IDX_EVENT_STATUS:  rd_mux = {31'h0, ua_reg};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // Protection and sense byte; fixed bits are never stored
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            prot_sense_reg <= PROT_SENSE_RST;
        else
            prot_sense_reg <= prot_sense_next;
    end

    // Queue byte; a refused write leaves it as it was
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            queue_control_reg <= QUEUE_CONTROL_RST;
        else
            queue_control_reg <= queue_next;
    end

    // Tag owner, tag page, write protection and SBLP byte
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            app_tag_reg <= APP_TAG_CTRL_RST;
        else
            app_tag_reg <= app_tag_next;
    end

    // Busy timeout, kept only so that it reads back
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            busy_timeout_reg <= BUSY_TIMEOUT_RST;
        else
            busy_timeout_reg <= busy_next;
    end

    // Self-test estimate, refreshed every clock
    // Clamped before storage so software never sees a wrapped time
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            selftest_reg <= SELFTEST_DEFAULT;
        else
            selftest_reg <= selftest_next;
    end

    // Facts of the command under evaluation
    // Held in a register so the decoded outputs stay put between writes
    wire [4:0]  cmd_in_next = wr_cmd ? PWDATA[4:0] : cmd_in_reg;
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            cmd_in_reg <= 5'h00;
        else
            cmd_in_reg <= cmd_in_next;
    end

    // Sticky attention flag; a change of SBLP beats a clear
    // Cleared by writing one to bit 0 of the status word
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            ua_reg <= 1'b0;
        else
            ua_reg <= ua_next;
    end

    // One ready pulse per access, one wait state
    // The held PENABLE cannot start a second access while ready is up
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            pready_reg <= 1'b0;
        else
            pready_reg <= access;
    end

    // Error flag rides with ready
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            pslverr_reg <= 1'b0;
        else
            pslverr_reg <= err_next;
    end

    // Read data only for mapped reads; zero otherwise
    wire [31:0] prdata_next = (access && !PWRITE && mapped) ? rd_mux : 32'h0000_0000;
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            prdata_reg <= 32'h0000_0000;
        else
            prdata_reg <= prdata_next;
    end

    // Decoded outputs, one flop each; all lag the stored page by a clock
    // PI check enable for the command on hand
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            PI_CHECK_EN <= 1'b1;
        else
            PI_CHECK_EN <= pi_chk;
    end

    // Sense data format
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            SENSE_DESCRIPTOR <= 1'b1;
        else
            SENSE_DESCRIPTOR <= prot_sense_reg[DSENSE_BIT];
    end

    // Reordering freedom
    // Reserved codes never arrive here: their write is refused
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            REORDER_MODE <= 2'h0;
        else
            REORDER_MODE <= order_next;
    end

    // Queue error handling
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            QERR_MODE <= 2'h0;
        else
            QERR_MODE <= qerr_next;
    end

    // Application tag left untouched
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            APP_TAG_PRESERVE <= 1'b0;
        else
            APP_TAG_PRESERVE <= tag_keep;
    end

    // Application tag checked
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            APP_TAG_CHECK_EN <= 1'b0;
        else
            APP_TAG_CHECK_EN <= tag_chk;
    end

    // Expected tag taken from the tag page
    // Needs ATMPE, ATO, checking and support all at once
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            APP_TAG_FROM_PAGE <= 1'b0;
        else
            APP_TAG_FROM_PAGE <= tag_page;
    end

    // Unprotected write refused
    // Only meaningful while the medium carries protection information
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            REJECT_WRITE <= 1'b0;
        else
            REJECT_WRITE <= rej_next;
    end

    // Block length page served
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            SBLP_PAGE_EN <= 1'b0;
        else
            SBLP_PAGE_EN <= sblp;
    end

    // SPT code; switches in the same cycle as the page enable
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            SPT_VALUE <= 3'h0;
        else
            SPT_VALUE <= spt_next;
    end

    // Attention seen by the command path, a clock behind the flag
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            UNIT_ATTENTION <= 1'b0;
        else
            UNIT_ATTENTION <= ua_reg;
    end

    assign PRDATA  = prdata_reg;
    assign PREADY  = pready_reg;
    assign PSLVERR = pslverr_reg;

endmodule

// >>> cmp_control_page_chk.sv
// Port-level checks of the control page bank
`timescale 1ns/1ps
module cmp_control_page_chk
    import cmp_pkg::*;
(
    input logic        REF_CLK,
    input logic        RST,
    input logic        PSEL,
    input logic        PENABLE,
    input logic        PWRITE,
    input logic [5:0]  PADDR,
    input logic [31:0] PWDATA,
    input logic [3:0]  PSTRB,
    input logic [31:0] PRDATA,
    input logic        PREADY,
    input logic        PSLVERR,
    input logic        PI_CHECK_EN,
    input logic [1:0]  REORDER_MODE,
    input logic [1:0]  QERR_MODE,
    input logic        APP_TAG_PRESERVE,
    input logic        APP_TAG_CHECK_EN,
    input logic        APP_TAG_FROM_PAGE,
    input logic        SBLP_PAGE_EN,
    input logic [2:0]  SPT_VALUE,
    input logic        UNIT_ATTENTION
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // Access taken, decoded index and queue fields of the write
    wire       take = PSEL & PENABLE & ~PREADY;
    wire [3:0] idx = PADDR[5:2];
    wire [3:0] qam = PWDATA[7:4];
    wire       qwr = take & PWRITE & PSTRB[0] & (idx == IDX_QUEUE_CONTROL);
    // Reserved codes: modifier not 0, 1 or 8, or error code 10b
    wire bad_q = (qam != QAM_RESTRICTED && qam != QAM_UNRESTRICTED && qam != QAM_DISABLED)
        || PWDATA[2:1] == QERR_RESERVED;
    // Indices that the bank leaves unmapped
    wire hole = idx == 4'hB || idx == 4'hF;
    ready_one_wait_a: assert property (take |=> PREADY)
        else $error("ready late");
    queue_refuse_a: assert property (qwr && bad_q |=> PREADY && PSLVERR)
        else $error("reserved queue code taken");
    unmapped_err_a: assert property (take && hole |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    reorder_off_a: assert property (
        qwr && !bad_q && qam == QAM_DISABLED |-> ##3 REORDER_MODE == 2'h2)
        else $error("reordering not disabled");
    reorder_code_a: assert property (REORDER_MODE != 2'h3)
        else $error("bad reorder mode");
    qerr_code_a: assert property (QERR_MODE != QERR_RESERVED)
        else $error("reserved error mode");
    spt_code_a: assert property (SPT_VALUE == (SBLP_PAGE_EN ? SPT_SBLP_VAL : 3'h0))
        else $error("bad SPT");
    tag_check_a: assert property (APP_TAG_CHECK_EN |-> APP_TAG_PRESERVE && PI_CHECK_EN)
        else $error("tag checked without owner");
    tag_page_a: assert property (APP_TAG_FROM_PAGE |-> APP_TAG_CHECK_EN)
        else $error("tag from page wrongly");
    // A reset that clears SBLP is not a change of the setting
    sblp_attn_a: assert property (
        $changed(SBLP_PAGE_EN) && !$past(RST) |-> ##[0:2] UNIT_ATTENTION)
        else $error("no unit attention");
endmodule
bind cmp_control_page cmp_control_page_chk i_chk (
    .REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA,
    .PREADY, .PSLVERR, .PI_CHECK_EN, .REORDER_MODE, .QERR_MODE, .APP_TAG_PRESERVE,
    .APP_TAG_CHECK_EN, .APP_TAG_FROM_PAGE, .SBLP_PAGE_EN, .SPT_VALUE, .UNIT_ATTENTION
);

// >>> cmp_engine_model.sv
// Command engine stand-in that supplies the self-test estimate
`timescale 1ns/1ps
module cmp_engine_model
(
    input  logic        ref_clk,
    input  logic        rst,
    input  logic [31:0] secs_load,
    output logic [31:0] selftest_seconds
);
    // Registered so the value moves just after an edge; may exceed 16 bits
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            selftest_seconds <= 32'h0;
        else
            selftest_seconds <= secs_load;
    end
endmodule

// >>> cmp_pkg.sv
// Constants and types for the control mode page register bank
package cmp_pkg;

    // Page register byte indices (printed offsets are not all multiples of four)
    localparam logic [3:0] IDX_PAGE_HEADER    = 4'h0;
    localparam logic [3:0] IDX_PAGE_LENGTH    = 4'h1;
    localparam logic [3:0] IDX_PROT_SENSE     = 4'h2;
    localparam logic [3:0] IDX_QUEUE_CONTROL  = 4'h3;
    localparam logic [3:0] IDX_FIXED_FLAGS    = 4'h4;
    localparam logic [3:0] IDX_APP_TAG_CTRL   = 4'h5;
    localparam logic [3:0] IDX_OBSOLETE       = 4'h6;
    localparam logic [3:0] IDX_BUSY_TIMEOUT   = 4'h8;
    localparam logic [3:0] IDX_SELFTEST_TIME  = 4'hA;
    // Own registers: command evaluation and status
    localparam logic [3:0] IDX_CMD_INPUT      = 4'hC;
    localparam logic [3:0] IDX_CMD_RESULT     = 4'hD;
    localparam logic [3:0] IDX_EVENT_STATUS   = 4'hE;

    // Reset and fixed values
    localparam logic [7:0]  PAGE_HEADER_VAL   = 8'h0A;
    localparam logic [7:0]  PAGE_LENGTH_VAL   = 8'h0A;
    localparam logic [7:0]  PROT_SENSE_RST    = 8'h04;
    localparam logic [7:0]  QUEUE_CONTROL_RST = 8'h00;
    localparam logic [7:0]  APP_TAG_CTRL_RST  = 8'h00;
    localparam logic [15:0] BUSY_TIMEOUT_RST  = 16'h0000;
    localparam logic [15:0] SELFTEST_DEFAULT  = 16'h0000;
    localparam logic [2:0]  SPT_SBLP_VAL      = 3'h6;

    // Field positions in the settable bytes
    localparam int DPICZ_BIT  = 3;
    localparam int DSENSE_BIT = 2;
    localparam int QAM_LSB    = 4;
    localparam int QERR_LSB   = 1;
    localparam int ATO_BIT    = 7;
    localparam int ATMPE_BIT  = 5;
    localparam int RWWP_BIT   = 4;
    localparam int SBLP_BIT   = 3;

    // Writable masks of the mixed bytes
    localparam logic [7:0] PROT_SENSE_MASK = 8'h0C;
    localparam logic [7:0] QUEUE_CTRL_MASK = 8'hF6;
    localparam logic [7:0] APP_TAG_MASK    = 8'hB8;

    // Queue algorithm modifier and queue error codes
    typedef enum logic [1:0] {QO_RESTRICTED, QO_UNRESTRICTED, QO_DISABLED} cmp_order_type;
    localparam logic [3:0] QAM_RESTRICTED   = 4'h0;
    localparam logic [3:0] QAM_UNRESTRICTED = 4'h1;
    localparam logic [3:0] QAM_DISABLED     = 4'h8;
    localparam logic [1:0] QERR_BLOCK_ALL   = 2'h0;
    localparam logic [1:0] QERR_ABORT_ALL   = 2'h1;
    localparam logic [1:0] QERR_RESERVED    = 2'h2;
    localparam logic [1:0] QERR_ABORT_OWN   = 2'h3;

    // Self-test saturation value
    localparam logic [15:0] SELFTEST_SAT    = 16'hFFFF;

endpackage

// >>> test_cmp_control_page.sv
// Self-checking bench for the control page bank
`timescale 1ns/1ps
module test_cmp_control_page
    import cmp_pkg::*;
;
    typedef struct packed {logic [3:0] idx; logic [15:0] wd; logic [15:0] rd;
                           logic err;} cmp_row_type;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [5:0]  paddr = 6'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] secs = 32'h0;
    logic [31:0] prdata, st_secs;
    logic        pready, pslverr, pi_chk, sense, keep, tchk, tpage, rej, sblp, uattn, er, pc;
    logic [1:0]  reorder, qerr;
    logic [2:0]  spt;
    logic [15:0] rd, ex;
    int          n_mismatch = 0;
    int          n_tests = 0;
    logic [3:0]  qams [3] = '{QAM_RESTRICTED, QAM_UNRESTRICTED, QAM_DISABLED};
    logic [1:0]  qerrs [3] = '{QERR_BLOCK_ALL, QERR_ABORT_ALL, QERR_ABORT_OWN};
    logic [31:0] secs_in [3] = '{32'h0000_1234, 32'h0000_FFFF, 32'h0001_1170};
    // Write then read back; refused rows must leave the byte alone
    cmp_row_type rows [10] = '{'{IDX_PROT_SENSE, 16'h00FF, 16'h000C, 1'b0},
        '{IDX_FIXED_FLAGS, 16'h00FF, 16'h0000, 1'b0},
        '{IDX_QUEUE_CONTROL, 16'h0016, 16'h0016, 1'b0},
        '{IDX_QUEUE_CONTROL, 16'h0082, 16'h0082, 1'b0},
        '{IDX_QUEUE_CONTROL, 16'h0020, 16'h0082, 1'b1},
        '{IDX_QUEUE_CONTROL, 16'h0004, 16'h0082, 1'b1},
        '{IDX_QUEUE_CONTROL, 16'h0000, 16'h0000, 1'b0},
        '{IDX_BUSY_TIMEOUT, 16'h1234, 16'h1234, 1'b0},
        '{IDX_PAGE_HEADER, 16'h00FF, 16'h000A, 1'b0},
        '{IDX_OBSOLETE, 16'h00FF, 16'h0000, 1'b0}};
    always #2 ref_clk = ~ref_clk;
    cmp_engine_model i_eng (.ref_clk(ref_clk), .rst(rst), .secs_load(secs),
        .selftest_seconds(st_secs));
    cmp_control_page #(.SELFTEST_W(32)) i_dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SELFTEST_SECONDS(st_secs),
        .PI_CHECK_EN(pi_chk), .SENSE_DESCRIPTOR(sense), .REORDER_MODE(reorder), .QERR_MODE(qerr),
        .APP_TAG_PRESERVE(keep), .APP_TAG_CHECK_EN(tchk), .APP_TAG_FROM_PAGE(tpage),
        .REJECT_WRITE(rej), .SBLP_PAGE_EN(sblp), .SPT_VALUE(spt), .UNIT_ATTENTION(uattn));
    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_v({15'h0, got}, {15'h0, exp});
    endtask
    // One APB transfer; an idle edge first so no signal is assigned twice
    task automatic apb(input logic w, input logic [3:0] ix, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50)
        begin
            n_mismatch++;
            $display("ERROR %0t no ready from the bank", $time);
            finish_test();
        end
        rd = prdata[15:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check_reset();
        @(posedge ref_clk);
        chk_v({8'h0, pi_chk, sense, reorder, qerr, sblp, uattn}, 16'h00C0);
        apb(1'b0, IDX_PROT_SENSE, 16'h0);
        chk_v(rd, 16'h0004);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog well beyond the thousand or so cycles the run needs
    initial
    begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        check_reset();
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].idx, rows[i].wd);
            chk_b(er, rows[i].err);
            apb(1'b0, rows[i].idx, 16'h0);
            chk_v(rd, rows[i].rd);
        end
        // Every legal queue code reaches the mode outputs
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b1, IDX_QUEUE_CONTROL, {8'h00, qams[k], 1'b0, qerrs[k], 1'b0});
            repeat (2) @(posedge ref_clk);
            chk_v({14'h0, reorder}, k[15:0]);
            chk_v({14'h0, qerr}, {14'h0, qerrs[k]});
        end
        // Protection outputs against every command fact, both pages of flags
        for (int a = 1; a >= 0; a--)
            for (int d = 0; d < 2; d++)
                for (int c = 0; c < 16; c++)
                begin
                    apb(1'b1, IDX_APP_TAG_CTRL, a ? 16'h00B8 : 16'h0000);
                    apb(1'b1, IDX_PROT_SENSE, d ? 16'h000C : 16'h0000);
                    apb(1'b1, IDX_CMD_INPUT, c[15:0]);
                    repeat (2) @(posedge ref_clk);
                    pc = !(d[0] && c[0]);
                    ex = {12'h0, pc, d[0], a[0], a[0] && pc};
                    chk_v({12'h0, pi_chk, sense, keep, tchk}, ex);
                    ex = {14'h0, a[0] && pc && c[1], a[0] && c[3] && c[2]};
                    chk_v({14'h0, tpage, rej}, ex);
                    chk_v({12'h0, sblp, spt}, a ? 16'h000E : 16'h0000);
                end
        // Changing SBLP raises attention; rewriting it unchanged must not
        apb(1'b1, IDX_EVENT_STATUS, 16'h0001);
        apb(1'b1, IDX_APP_TAG_CTRL, 16'h0008);
        repeat (2) @(posedge ref_clk);
        chk_b(uattn, 1'b1);
        apb(1'b0, IDX_EVENT_STATUS, 16'h0);
        chk_v(rd, 16'h0001);
        apb(1'b1, IDX_EVENT_STATUS, 16'h0001);
        apb(1'b1, IDX_APP_TAG_CTRL, 16'h0018);
        repeat (2) @(posedge ref_clk);
        chk_b(uattn, 1'b0);
        // Self-test time passes through and saturates
        foreach (secs_in[i])
        begin
            secs <= secs_in[i];
            repeat (3) @(posedge ref_clk);
            apb(1'b0, IDX_SELFTEST_TIME, 16'h0);
            chk_v(rd, secs_in[i] > 32'hFFFF ? SELFTEST_SAT : secs_in[i][15:0]);
        end
        apb(1'b0, 4'hF, 16'h0);
        chk_b(er, 1'b1);
        chk_v(rd, 16'h0000);
        // Mid-run reset restores the defaults
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        check_reset();
        finish_test();
    end
endmodule
